// >>> hdl/fskdm_pkg.sv
// Constants for the FSK receive demodulator setup block
package fskdm_pkg;
  // Register byte offsets
  localparam logic [7:0] FSKDM_ADDR_DEMOD  = 8'h00;
  localparam logic [7:0] FSKDM_ADDR_DETECT = 8'h04;
  localparam logic [7:0] FSKDM_ADDR_STATUS = 8'h08;
  // Reset values of the two setup words
  localparam logic [31:0] FSKDM_DEMOD_RST  = 32'h0000_0000;
  localparam logic [31:0] FSKDM_DETECT_RST = 32'h0000_0000;
  // Demodulator setup word fields
  localparam int FSKDM_SEL_LSB    = 4;
  localparam int FSKDM_SEL_W      = 3;
  localparam int FSKDM_ODD_BIT    = 7;
  localparam int FSKDM_PAR_LSB    = 8;
  localparam int FSKDM_PAR_W      = 2;
  localparam int FSKDM_CBW_LSB    = 10;
  localparam int FSKDM_BW_W       = 10;
  localparam int FSKDM_PBW_LSB    = 20;
  // Detector setup word fields
  localparam int FSKDM_SLV_LSB    = 4;
  localparam int FSKDM_LVL_W      = 7;
  localparam int FSKDM_VIT_BIT    = 11;
  localparam int FSKDM_PFIX_BIT   = 12;
  localparam int FSKDM_PMEM_LSB   = 13;
  localparam int FSKDM_PMEM_W     = 2;
  localparam int FSKDM_RCV_LSB    = 15;
  localparam int FSKDM_PQT_LSB    = 22;
  localparam int FSKDM_PQT_W      = 4;
  // Demodulator select codes
  localparam logic [2:0] FSKDM_SEL_LINEAR = 3'h0;
  localparam logic [2:0] FSKDM_SEL_CORR2  = 3'h1;
  localparam logic [2:0] FSKDM_SEL_CORR3  = 3'h2;
  localparam logic [2:0] FSKDM_SEL_CORR4  = 3'h3;
  // Path memory lengths in bits, indexed by the two-bit code
  localparam logic [5:0] FSKDM_PMEM_LEN0 = 6'h04;
  localparam logic [5:0] FSKDM_PMEM_LEN1 = 6'h06;
  localparam logic [5:0] FSKDM_PMEM_LEN2 = 6'h08;
  localparam logic [5:0] FSKDM_PMEM_LEN3 = 6'h20;
  // Sample width and delay line depth
  localparam int FSKDM_SAMP_W = 12;
  localparam int FSKDM_DEPTH  = 64;
  // Symbol codes
  localparam logic [1:0] FSKDM_SYM_ZERO = 2'h0;
  localparam logic [1:0] FSKDM_SYM_POS1 = 2'h1;
  localparam logic [1:0] FSKDM_SYM_NEG1 = 2'h3;
  localparam logic [1:0] FSKDM_SYM_NEG3 = 2'h0;
  localparam logic [1:0] FSKDM_SYM_N1_4 = 2'h1;
  localparam logic [1:0] FSKDM_SYM_P1_4 = 2'h2;
  localparam logic [1:0] FSKDM_SYM_POS3 = 2'h3;
  // Operating mode of the active configuration
  typedef enum logic [2:0] {
    FSKDM_MODE_OFF, FSKDM_MODE_LIN2, FSKDM_MODE_COR2, FSKDM_MODE_COR3, FSKDM_MODE_COR4
  } fskdm_mode_e;
endpackage

// >>> hdl/fskdm_path_delay.sv
// Symbol delay line that models the detector path memory latency
`timescale 1ns/1ps
`default_nettype none
module fskdm_path_delay
  import fskdm_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_shift,
  input  wire logic [1:0] i_sym,
  input  wire logic [6:0] i_tap,
  output logic      [1:0] o_sym
);
  logic [1:0] mem_r [0:FSKDM_DEPTH-1];
  logic [6:0] tap_m1;

  // Shift one entry per accepted symbol; stall keeps the order intact
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < FSKDM_DEPTH; i++) begin
        mem_r[i] <= 2'h0;
      end
    end else if (i_shift) begin
      mem_r[0] <= i_sym;
      for (int i = 1; i < FSKDM_DEPTH; i++) begin
        mem_r[i] <= mem_r[i-1];
      end
    end
  end

  // Tap of zero is never requested; the top only passes 8 to 64
  assign tap_m1 = i_tap - 7'h01;
  assign o_sym  = mem_r[tap_m1[5:0]];
endmodule
`default_nettype wire

// >>> hdl/fskdm_top.sv
// FSK receive demodulator setup decode, slicing and detector latency
//
// Behaviour
// - Select 001/010/011 routes through correlator.
// - Select 000 uses linear two-level path.
// - Bit 11 chooses Viterbi or threshold 3FSK.
// - Path memory 4/6/8/32 from bits 13-14.
// - 4FSK slices at zero and symmetric thresholds.
// - Viterbi adds twice path memory latency.
`timescale 1ns/1ps
`default_nettype none
module fskdm_top
  import fskdm_pkg::*;
(
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_reset,
  input  wire logic [7:0]                     i_addr,
  input  wire logic [31:0]                    i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [31:0]                    o_rdata,
  input  wire logic                           i_sample_valid,
  input  wire logic signed [FSKDM_SAMP_W-1:0] i_corr_sample,
  input  wire logic signed [FSKDM_SAMP_W-1:0] i_lin_sample,
  input  wire logic signed [FSKDM_SAMP_W-1:0] i_lin_envelope,
  output logic                                o_path_corr,
  output logic                                o_path_lin,
  output logic                                o_viterbi_on,
  output logic      [5:0]                     o_path_len,
  output logic      [6:0]                     o_latency,
  output logic      [FSKDM_BW_W-1:0]          o_corr_bw,
  output logic                                o_corr_odd,
  output logic      [FSKDM_PAR_W-1:0]         o_corr_parity,
  output logic      [FSKDM_BW_W-1:0]          o_post_bw,
  output logic                                o_phase_fix,
  output logic      [FSKDM_LVL_W-1:0]         o_recovery_level,
  output logic      [FSKDM_PQT_W-1:0]         o_preamble_qualify,
  output logic      [1:0]                     o_rx_symbol,
  output logic                                o_rx_valid
);
  logic [31:0] stage_demod_r;
  logic [31:0] stage_detect_r;
  logic [31:0] act_demod_r;
  logic [31:0] act_detect_r;
  logic        pending_r;
  logic        wr_demod;
  logic        wr_detect;
  logic [2:0]  sel;
  logic        vit_on;
  logic [1:0]  pmem_code;
  logic [5:0]  path_len_nxt;
  fskdm_mode_e mode_nxt;
  logic signed [FSKDM_SAMP_W-1:0] thr_pos;
  logic signed [FSKDM_SAMP_W-1:0] thr_neg;
  logic [1:0]  sym_nxt;
  logic        sym_ok_nxt;
  logic [1:0]  sym_r;
  logic        sym_vld_r;
  logic [1:0]  dly_sym;

  assign wr_demod  = i_wr && (i_addr == FSKDM_ADDR_DEMOD);
  assign wr_detect = i_wr && (i_addr == FSKDM_ADDR_DETECT);

  // Staging words take the whole bus word in one strobe
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      stage_demod_r  <= FSKDM_DEMOD_RST;
      stage_detect_r <= FSKDM_DETECT_RST;
    end else begin
      if (wr_demod) begin
        stage_demod_r <= i_wdata;
      end
      if (wr_detect) begin
        stage_detect_r <= i_wdata;
      end
    end
  end

  // Active copy loads one cycle after each write; back-to-back writes reload it every cycle
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pending_r    <= 1'b0;
      act_demod_r  <= FSKDM_DEMOD_RST;
      act_detect_r <= FSKDM_DETECT_RST;
    end else begin
      pending_r <= wr_demod || wr_detect;
      if (pending_r) begin
        act_demod_r  <= stage_demod_r;
        act_detect_r <= stage_detect_r;
      end
    end
  end

  assign sel       = act_demod_r[FSKDM_SEL_LSB +: FSKDM_SEL_W];
  assign vit_on    = act_detect_r[FSKDM_VIT_BIT];
  assign pmem_code = act_detect_r[FSKDM_PMEM_LSB +: FSKDM_PMEM_W];
  assign thr_pos   = FSKDM_SAMP_W'({1'b0, act_detect_r[FSKDM_SLV_LSB +: FSKDM_LVL_W]});
  assign thr_neg   = -thr_pos;

  // Mode decode; unlisted select codes leave the receiver without a path
  always_comb begin
    unique case (sel)
      FSKDM_SEL_LINEAR: mode_nxt = FSKDM_MODE_LIN2;
      FSKDM_SEL_CORR2:  mode_nxt = FSKDM_MODE_COR2;
      FSKDM_SEL_CORR3:  mode_nxt = FSKDM_MODE_COR3;
      FSKDM_SEL_CORR4:  mode_nxt = FSKDM_MODE_COR4;
      default:          mode_nxt = FSKDM_MODE_OFF;
    endcase
  end

  // Path memory length lookup
  always_comb begin
    unique case (pmem_code)
      2'h0: path_len_nxt = FSKDM_PMEM_LEN0;
      2'h1: path_len_nxt = FSKDM_PMEM_LEN1;
      2'h2: path_len_nxt = FSKDM_PMEM_LEN2;
      2'h3: path_len_nxt = FSKDM_PMEM_LEN3;
    endcase
  end

  // Slicer: fixed zero for two-level correlator, envelope for linear, symmetric levels else
  always_comb begin
    sym_nxt    = FSKDM_SYM_ZERO;
    sym_ok_nxt = i_sample_valid;
    unique case (mode_nxt)
      FSKDM_MODE_LIN2: sym_nxt = {1'b0, i_lin_sample > i_lin_envelope};
      FSKDM_MODE_COR2: sym_nxt = {1'b0, ~i_corr_sample[FSKDM_SAMP_W-1]};
      FSKDM_MODE_COR3: begin
        if (i_corr_sample > thr_pos) begin
          sym_nxt = FSKDM_SYM_POS1;
        end else if (i_corr_sample < thr_neg) begin
          sym_nxt = FSKDM_SYM_NEG1;
        end else begin
          sym_nxt = FSKDM_SYM_ZERO;
        end
      end
      FSKDM_MODE_COR4: begin
        if (i_corr_sample > thr_pos) begin
          sym_nxt = FSKDM_SYM_POS3;
        end else if (!i_corr_sample[FSKDM_SAMP_W-1]) begin
          sym_nxt = FSKDM_SYM_P1_4;
        end else if (i_corr_sample >= thr_neg) begin
          sym_nxt = FSKDM_SYM_N1_4;
        end else begin
          sym_nxt = FSKDM_SYM_NEG3;
        end
      end
      FSKDM_MODE_OFF: sym_ok_nxt = 1'b0;
    endcase
  end

  // Registered slicer decision; held between samples so idle inputs never leak out
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sym_r     <= 2'h0;
      sym_vld_r <= 1'b0;
    end else begin
      sym_vld_r <= sym_ok_nxt;
      if (sym_ok_nxt) begin
        sym_r <= sym_nxt;
      end
    end
  end

  // Latency line sized for the longest path memory; shorter settings tap earlier
  fskdm_path_delay u_delay (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_shift   (sym_vld_r),
    .i_sym     (sym_r),
    .i_tap     (o_latency),
    .o_sym     (dly_sym)
  );

  // Symbol output; delayed path only in 3FSK with the Viterbi detector on
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rx_symbol <= 2'h0;
      o_rx_valid  <= 1'b0;
    end else begin
      o_rx_valid  <= sym_vld_r;
      if (sym_vld_r) begin
        if (o_viterbi_on) begin
          o_rx_symbol <= dly_sym;
        end else begin
          o_rx_symbol <= sym_r;
        end
      end
    end
  end

  // Decoded setup outputs to the datapath, all from flops
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_path_corr        <= 1'b0;
      o_path_lin         <= 1'b0;
      o_viterbi_on       <= 1'b0;
      o_path_len         <= FSKDM_PMEM_LEN0;
      o_latency          <= 7'h08;
      o_corr_bw          <= '0;
      o_corr_odd         <= 1'b0;
      o_corr_parity      <= '0;
      o_post_bw          <= '0;
      o_phase_fix        <= 1'b0;
      o_recovery_level   <= '0;
      o_preamble_qualify <= '0;
    end else begin
      o_path_corr        <= (mode_nxt == FSKDM_MODE_COR2) || (mode_nxt == FSKDM_MODE_COR3)
                            || (mode_nxt == FSKDM_MODE_COR4);
      o_path_lin         <= (mode_nxt == FSKDM_MODE_LIN2);
      o_viterbi_on       <= vit_on && (mode_nxt == FSKDM_MODE_COR3);
      o_path_len         <= path_len_nxt;
      o_latency          <= {path_len_nxt, 1'b0};
      o_corr_bw          <= act_demod_r[FSKDM_CBW_LSB +: FSKDM_BW_W];
      o_corr_odd         <= act_demod_r[FSKDM_ODD_BIT];
      o_corr_parity      <= act_demod_r[FSKDM_PAR_LSB +: FSKDM_PAR_W];
      o_post_bw          <= act_demod_r[FSKDM_PBW_LSB +: FSKDM_BW_W];
      o_phase_fix        <= act_detect_r[FSKDM_PFIX_BIT];
      o_recovery_level   <= act_detect_r[FSKDM_RCV_LSB +: FSKDM_LVL_W];
      o_preamble_qualify <= act_detect_r[FSKDM_PQT_LSB +: FSKDM_PQT_W];
    end
  end

  // Read port: setup words are write-only and read as zero, like unmapped offsets
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd && (i_addr == FSKDM_ADDR_STATUS)) begin
      o_rdata <= {12'h000, pending_r, o_rx_symbol, o_latency, o_path_len, o_viterbi_on, sel};
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  property p_corr_route;
    @(posedge i_ref_clk) disable iff (i_reset)
    (sel == FSKDM_SEL_CORR2 || sel == FSKDM_SEL_CORR3 || sel == FSKDM_SEL_CORR4)
      |=> (o_path_corr && !o_path_lin);
  endproperty
  a_corr_route: assert property (p_corr_route) else $error("correlator path not chosen");

  property p_lin_route;
    @(posedge i_ref_clk) disable iff (i_reset)
    (sel == FSKDM_SEL_LINEAR) |=> (o_path_lin && !o_path_corr);
  endproperty
  a_lin_route: assert property (p_lin_route) else $error("linear path not chosen");

  property p_viterbi_sel;
    @(posedge i_ref_clk) disable iff (i_reset)
    (sel == FSKDM_SEL_CORR3) |=> (o_viterbi_on == $past(vit_on));
  endproperty
  a_viterbi_sel: assert property (p_viterbi_sel) else $error("detector choice wrong");

  property p_path_len;
    @(posedge i_ref_clk) disable iff (i_reset)
    (pmem_code == 2'h3) |=> (o_path_len == 6'h20);
  endproperty
  a_path_len: assert property (p_path_len) else $error("path memory length wrong");

  property p_latency;
    @(posedge i_ref_clk) disable iff (i_reset)
    1'b1 |=> (o_latency == {o_path_len, 1'b0});
  endproperty
  a_latency: assert property (p_latency) else $error("latency not twice path memory");

  property p_apply;
    @(posedge i_ref_clk) disable iff (i_reset)
    pending_r |=> (act_demod_r == $past(stage_demod_r)) && (act_detect_r == $past(stage_detect_r));
  endproperty
  a_apply: assert property (p_apply) else $error("latched word not applied");

  property p_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
    (!pending_r && i_wr) |=> $stable(act_demod_r) && $stable(act_detect_r);
  endproperty
  a_hold: assert property (p_hold) else $error("active word changed during write");

  property p_four_top;
    @(posedge i_ref_clk) disable iff (i_reset)
    (mode_nxt == FSKDM_MODE_COR4 && i_sample_valid && i_corr_sample > thr_pos && !o_viterbi_on)
      |=> ##1 (o_rx_valid && o_rx_symbol == FSKDM_SYM_POS3);
  endproperty
  a_four_top: assert property (p_four_top) else $error("outer positive symbol missed");

  property p_four_inner;
    @(posedge i_ref_clk) disable iff (i_reset)
    (mode_nxt == FSKDM_MODE_COR4 && i_sample_valid && i_corr_sample < 0
      && i_corr_sample >= thr_neg && !o_viterbi_on)
      |=> ##1 (o_rx_symbol == FSKDM_SYM_N1_4);
  endproperty
  a_four_inner: assert property (p_four_inner) else $error("inner negative symbol missed");
endmodule
`default_nettype wire

// >>> dv/fskdm_tx_model.sv
// Remote transmitter model that presents demodulated samples to the receiver
`timescale 1ns/1ps
`default_nettype none
module fskdm_tx_model
  import fskdm_pkg::*;
#(
  parameter int FREQ_ERR = 50
) (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_reset,
  input  wire logic                           i_send,
  input  wire logic signed [FSKDM_SAMP_W-1:0] i_level,
  output logic                                o_valid,
  output logic signed      [FSKDM_SAMP_W-1:0] o_corr,
  output logic signed      [FSKDM_SAMP_W-1:0] o_lin,
  output logic signed      [FSKDM_SAMP_W-1:0] o_env
);
  logic [FSKDM_SAMP_W-1:0] idle_r;
  // Idle pattern moves every cycle so stale sample values are never trusted
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) idle_r <= 12'h5a5;
    else idle_r <= idle_r + 12'h0a7;
  end
  // Linear path carries a fixed carrier offset, which the envelope tracks
  assign o_valid = i_send;
  assign o_corr  = i_send ? i_level : $signed(idle_r);
  assign o_lin   = i_send ? i_level + 12'(FREQ_ERR) : $signed(~idle_r);
  assign o_env   = 12'(FREQ_ERR);
endmodule
`default_nettype wire

// >>> dv/tb_fskdm_top.sv
// Self-checking bench for the FSK receive demodulator setup block
`timescale 1ns/1ps
`default_nettype none
module tb_fskdm_top
  import fskdm_pkg::*;
;
  logic        clk, rst, wr, rd, send, sv, pc, pl, von, odd, pfix, vld, last_vld;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic [5:0]  plen;
  logic [6:0]  lat, rcv;
  logic [9:0]  cbw, pbw;
  logic [1:0]  par, sym, last_sym;
  logic [3:0]  pqt;
  logic signed [FSKDM_SAMP_W-1:0] lvl, corr, lin, env;
  int          mismatches, checked, cycles, k;
  int          lv3[4] = '{29, 28, -28, -29};
  int          lv4[6] = '{57, 56, 0, -1, -56, -57};
  logic [1:0]  ex3[4] = '{FSKDM_SYM_POS1, FSKDM_SYM_ZERO, FSKDM_SYM_ZERO, FSKDM_SYM_NEG1};
  logic [1:0]  ex4[6] = '{FSKDM_SYM_POS3, FSKDM_SYM_P1_4, FSKDM_SYM_P1_4, FSKDM_SYM_N1_4,
                          FSKDM_SYM_N1_4, FSKDM_SYM_NEG3};
  logic [5:0]  lens[4] = '{6'h04, 6'h06, 6'h08, 6'h20};

  fskdm_tx_model u_tx (.i_ref_clk(clk), .i_reset(rst), .i_send(send), .i_level(lvl),
    .o_valid(sv), .o_corr(corr), .o_lin(lin), .o_env(env));
  fskdm_top u_dut (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sample_valid(sv), .i_corr_sample(corr),
    .i_lin_sample(lin), .i_lin_envelope(env), .o_path_corr(pc), .o_path_lin(pl),
    .o_viterbi_on(von), .o_path_len(plen), .o_latency(lat), .o_corr_bw(cbw),
    .o_corr_odd(odd), .o_corr_parity(par), .o_post_bw(pbw), .o_phase_fix(pfix),
    .o_recovery_level(rcv), .o_preamble_qualify(pqt), .o_rx_symbol(sym), .o_rx_valid(vld));

  // 50 MHz reference clock
  always #10 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Decoded outputs follow the write edge by two cycles
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // One transmitted sample; the sliced symbol shows one edge after it is taken
  task automatic sample(input int v);
    @(posedge clk);
    send <= 1'b1;
    lvl <= 12'(v);
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1 last_vld = vld;
    last_sym = sym;
  endtask

  function automatic int kround(input int num, input int den);
    return (2 * num + den) / (2 * den);
  endfunction

  function automatic logic [31:0] dword(input logic [2:0] s, input int cb, input int pb,
                                        input int kk);
    int half;
    half = kk[0] ? (kk + 1) / 2 : kk / 2;
    return {2'h0, 10'(pb), 10'(cb), half[0] ? 2'h2 : 2'h0, kk[0], s, 4'h0};
  endfunction

  function automatic logic [31:0] tword(input int slv, input logic vit, input logic [1:0] pm);
    return {6'h00, 4'hf, 7'h1f, pm, 1'b1, vit, 7'(slv), 4'h0};
  endfunction

  // Guard against a hung handshake
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; send = 1'b0;
    addr = 8'h00; wdata = 32'h0000_0000; lvl = '0;
    mismatches = 0; checked = 0; cycles = 0;
    repeat (12) @(posedge clk);
    #1 check("path_len_rst", plen, 6'h04);
    check("latency_rst", lat, 7'h08);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("path_lin_rst", pl, 1'b1);
    rd_reg(FSKDM_ADDR_STATUS, r);
    check("status_rst", r, 32'h0000_2040);
    // Setup words are write-only; an unmapped address also reads zero
    for (int i = 0; i < 4; i++) if (i != 2) begin
      rd_reg(8'(i * 4), r);
      check("wo_read", r, 32'h0000_0000);
    end
    // Select codes 0 to 4, including an undefined one that must not pass samples
    for (int s = 0; s < 5; s++) begin
      wr_reg(FSKDM_ADDR_DEMOD, dword(3'(s), 0, 0, 0));
      settle();
      check("path_corr", pc, s >= 1 && s <= 3);
      check("path_lin", pl, s == 0);
      sample(100);
      check("rx_valid", last_vld, s < 5 - 1);
    end
    // 2FSK at 4.8 kHz deviation, 2 MHz sample clock, cutoff at a 9600 bit/s rate
    k = kround(100000, 4800);
    wr_reg(FSKDM_ADDR_DEMOD, dword(FSKDM_SEL_CORR2, 2000000 * k / 400000,
      int'($ceil(2048.0 * 3.14159265 * 9600.0 / 2.0e6)), k));
    settle();
    check("corr_bw", cbw, 10'h069);
    check("corr_odd", odd, 1'b1);
    check("corr_parity", par, 2'h2);
    check("post_bw", pbw, 10'h01f);
    sample(0);
    check("corr2_zero", last_sym[0], 1'b1);
    sample(-1);
    check("corr2_neg", last_sym[0], 1'b0);
    // Alternating preamble, then a run of eight equal bits
    for (int i = 0; i < 24; i++) begin
      sample((i < 16 && i[0]) ? -100 : 100);
      check("pre2", last_sym[0], !(i < 16 && i[0]));
    end
    // Doubled correlator bandwidth for wider frequency error tolerance
    k = kround(100000, 2 * 4800);
    wr_reg(FSKDM_ADDR_DEMOD, dword(FSKDM_SEL_CORR2, 2000000 * k / 400000, 31, k));
    settle();
    check("corr_bw_x2", cbw, 10'h032);
    // A new select must not take effect before the whole word is applied
    wr_reg(FSKDM_ADDR_DEMOD, dword(FSKDM_SEL_LINEAR, 0, 0, 0));
    @(posedge clk);
    #1 check("apply_early", pl, 1'b0);
    @(posedge clk);
    #1 check("apply_late", pl, 1'b1);
    sample(1);
    check("lin_above", last_sym[0], 1'b1);
    sample(0);
    check("lin_equal", last_sym[0], 1'b0);
    // 3FSK threshold slicing, 2.4 kHz deviation
    k = kround(100000, 4800);
    wr_reg(FSKDM_ADDR_DEMOD, dword(FSKDM_SEL_CORR3, 0, 0, k));
    wr_reg(FSKDM_ADDR_DETECT, tword(57 * 2400 * k / 100000, 1'b0, 2'h0));
    settle();
    check("viterbi_off", von, 1'b0);
    check("phase_fix", pfix, 1'b1);
    check("recovery_lvl", rcv, 7'h1f);
    check("pream_qual", pqt, 4'hf);
    foreach (lv3[i]) begin
      sample(lv3[i]);
      check("slice3", last_sym, ex3[i]);
    end
    // Preamble of ones gives a symbol transition on every bit
    for (int i = 0; i < 40; i++) begin
      sample(i[0] ? -100 : 100);
      check("pre3", last_sym, i[0] ? FSKDM_SYM_NEG1 : FSKDM_SYM_POS1);
    end
    // 4FSK, inner 1.2 kHz, outer 3.6 kHz, coefficient at the nearest allowed value 20
    wr_reg(FSKDM_ADDR_DEMOD, dword(FSKDM_SEL_CORR4, 0, 0, 20));
    wr_reg(FSKDM_ADDR_DETECT, tword(78 * 3600 * 20 / 100000, 1'b1, 2'h0));
    settle();
    check("viterbi_4fsk", von, 1'b0);
    foreach (lv4[i]) begin
      sample(lv4[i]);
      check("slice4", last_sym, ex4[i]);
    end
    // Outer symbol preamble, then a balanced inner body
    for (int i = 0; i < 16; i++) begin
      sample(i[0] ? 100 : -100);
      check("pre4", last_sym, i[0] ? FSKDM_SYM_POS3 : FSKDM_SYM_NEG3);
    end
    for (int i = 0; i < 8; i++) begin
      sample(i[0] ? -20 : 20);
      check("body4", last_sym, i[0] ? FSKDM_SYM_N1_4 : FSKDM_SYM_P1_4);
    end
    // Path memory codes with the Viterbi detector on
    wr_reg(FSKDM_ADDR_DEMOD, dword(FSKDM_SEL_CORR3, 0, 0, 21));
    for (int c = 0; c < 4; c++) begin
      wr_reg(FSKDM_ADDR_DETECT, tword(28, 1'b1, 2'(c)));
      settle();
      check("viterbi_on", von, 1'b1);
      check("path_len", plen, lens[c]);
      check("latency", lat, 7'(2 * lens[c]));
    end
    // A lone positive symbol surfaces eight samples later with memory length 4
    wr_reg(FSKDM_ADDR_DETECT, tword(28, 1'b1, 2'h0));
    settle();
    for (int i = 0; i < 9; i++) sample(i == 0 ? 100 : 0);
    check("viterbi_delay", last_sym, FSKDM_SYM_POS1);
    rd_reg(FSKDM_ADDR_STATUS, r);
    check("status_end", r, 32'h0002_204a);
    test_done();
  end
endmodule
`default_nettype wire
